// ### logic/ssc_collector.sv
/*
  SMI status collector: four status registers, two enable registers and
  a control register behind an Avalon-MM slave, plus group SMI routing
  to the SMI pin, the serial interrupt stream and the PME logic.
  Assumes peripheral events come from logic on clk_in; printer
  acknowledge, infrared receive, I/O pins and the main resets are pins.
*/
// Behaviour
// - Peripheral status resets to 0x02; bit 1 forced high on every reset kind.
// - Defined peripheral status bits mirror their sources; writes never clear them.
// - Bit 1 reads one while port inactive, else follows printer acknowledge.
// - Bits 2..5 carry second serial, first serial, floppy, MIDI; others reserved.
// - Input status bit 0 mouse, bit 1 keyboard, both mirror their sources.
// - Input status bit 2 set by any edge on selected infrared receive input.
// - Reading input status clears infrared bit; later edges set it again.
// - Input status bit 4 latches aux line event; write one clears, zero keeps.
// - Clearing aux status leaves the aux event itself untouched.
// - Pin status bits latch pin events, cleared only by writing one.
// - Pin registers map pins 20-22,24-26,60 and 30-33,41-43,61 in order.
// - A status bit reaches group SMI only when its enable bit is one.
// - Group SMI drives the SMI pin only while enable bit 7 is set.
// - Group SMI goes to the serial stream only while enable bit 6 set.
`timescale 1ns/1ps

module ssc_collector (
  input wire logic clk_in, // 125 MHz system clock
  input wire logic reset_n_in, // Standby power-on reset, active low
  input wire logic main_power_reset_in, // Main power-on reset, active high
  input wire logic hard_reset_in, // Hard reset, active high
  input wire logic soft_reset_in, // Soft reset, active high
  input wire ssc_pkg::ssc_events_t events_in, // Peripheral event levels
  input wire logic printer_acknowledge_in, // Printer acknowledge pin level
  input wire logic infrared_receive_a_in, // First infrared receive pin
  input wire logic infrared_receive_b_in, // Second infrared receive pin
  input wire logic [7:0] io_pins_low_in, // Pins 20,21,22,-,24,25,26,60
  input wire logic [7:0] io_pins_high_in, // Pins 30..33,41,42,43,61
  input wire ssc_pkg::ssc_avs_req_t avs_req_in, // Avalon-MM request
  output logic [31:0] avs_readdata_out, // Avalon-MM read data
  output logic avs_waitrequest_out, // Avalon-MM wait request
  output logic smi_output_pin_n_out, // SMI pin level, active low
  output logic smi_output_pin_oe_out, // SMI pin output enable
  output logic smi_serial_request_out, // Group SMI onto serial stream
  output logic smi_pme_request_out // Group SMI into PME logic
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic [ssc_pkg::SYNC_W-1:0] raw_pins;
  logic [ssc_pkg::SYNC_W-1:0] sync_pins;
  logic ack_s;
  logic ir_a_s;
  logic ir_b_s;
  logic any_reset_s;
  logic [7:0] pins_lo_s;
  logic [7:0] pins_hi_s;

  assign raw_pins = {main_power_reset_in, hard_reset_in, soft_reset_in,
                     printer_acknowledge_in, infrared_receive_a_in,
                     infrared_receive_b_in, io_pins_low_in, io_pins_high_in};

  ssc_sync2 #(
    .WIDTH(ssc_pkg::SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in(raw_pins),
    .sync_out(sync_pins)
  );

  // Unpack the synchronised bundle
  assign any_reset_s = |sync_pins[21:19];
  assign ack_s = sync_pins[18];
  assign ir_a_s = sync_pins[17];
  assign ir_b_s = sync_pins[16];
  assign pins_lo_s = sync_pins[15:8];
  assign pins_hi_s = sync_pins[7:0];

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // Latch with write-one clear; a set in the clear cycle wins
  function automatic logic [7:0] w1c(input logic [7:0] cur, input logic [7:0] set,
                                     input logic [7:0] clr);
    w1c = (cur & ~clr) | set;
  endfunction

  // Read mux, unmapped indices return zero
  function automatic logic [7:0] read_mux(input logic [5:0] idx,
                                          input ssc_pkg::ssc_state_t s);
    case (idx)
      ssc_pkg::IDX_STS_PERIPH: read_mux = s.sts_periph;
      ssc_pkg::IDX_STS_INPUT: read_mux = s.sts_input;
      ssc_pkg::IDX_STS_PINS_LO: read_mux = s.sts_pins_lo;
      ssc_pkg::IDX_STS_PINS_HI: read_mux = s.sts_pins_hi;
      ssc_pkg::IDX_EN_PERIPH: read_mux = s.en_periph;
      ssc_pkg::IDX_EN_INPUT: read_mux = s.en_input;
      ssc_pkg::IDX_CTRL: read_mux = s.ctrl;
      default: read_mux = ssc_pkg::RST_ZERO8;
    endcase
  endfunction

  ssc_pkg::ssc_state_t q_ff;
  ssc_pkg::ssc_state_t nxt_q;
  logic ir_sel;
  logic ir_edge;
  logic rd_acc;
  logic wr_acc;
  logic [5:0] idx;
  logic [7:0] wd;
  logic [7:0] ir_clr;
  logic [7:0] aux_clr;
  logic [7:0] ir_next;
  logic [7:0] aux_next;

  ////////////////////////////////////////////////////////////////////////
  // Infrared select happens before edge detection
  assign ir_sel = q_ff.ctrl[ssc_pkg::POS_IR_SELECT] ? ir_b_s : ir_a_s;
  assign ir_edge = ir_sel ^ q_ff.ir_prev;

  // Bus accept is the edge where waitrequest is seen low
  assign idx = avs_req_in.address[7:2];
  assign rd_acc = avs_req_in.read && !q_ff.waitrequest;
  assign wr_acc = avs_req_in.write && !q_ff.waitrequest && avs_req_in.byteenable[0];
  assign wd = avs_req_in.writedata[7:0];

  // Read clears only the infrared bit that was actually returned
  assign ir_clr = (rd_acc && idx == ssc_pkg::IDX_STS_INPUT) ?
                  (q_ff.readdata[7:0] & 8'h04) : 8'h00;
  assign aux_clr = (wr_acc && idx == ssc_pkg::IDX_STS_INPUT) ?
                   (wd & 8'h10) : 8'h00;

  // Latched input bits; a function result cannot be indexed, so name it
  assign ir_next = w1c(q_ff.sts_input, {5'h00, ir_edge, 2'h0}, ir_clr);
  assign aux_next = w1c(q_ff.sts_input, {3'h0, events_in.aux_line_event, 4'h0},
                        aux_clr);

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.ir_prev = ir_sel;
    // Bus handshake: one wait cycle, data stands when waitrequest drops
    if ((avs_req_in.read || avs_req_in.write) && q_ff.waitrequest)
    begin
      nxt_q.waitrequest = 1'b0;
      nxt_q.readdata = {24'h00_0000, read_mux(idx, q_ff)};
    end
    else
    begin
      nxt_q.waitrequest = 1'b1;
    end
    // Live mirrors, no write path at all
    nxt_q.sts_periph = 8'h00;
    nxt_q.sts_periph[ssc_pkg::POS_PARALLEL] = any_reset_s ||
      !q_ff.ctrl[ssc_pkg::POS_PORT_ACTIVE] || ack_s;
    nxt_q.sts_periph[ssc_pkg::POS_SERIAL2] = events_in.second_serial_event;
    nxt_q.sts_periph[ssc_pkg::POS_SERIAL1] = events_in.first_serial_event;
    nxt_q.sts_periph[ssc_pkg::POS_FLOPPY] = events_in.floppy_event;
    nxt_q.sts_periph[ssc_pkg::POS_MIDI] = events_in.midi_port_event;
    // Input devices: mirrors, read-clear edge latch, write-one-clear latch
    nxt_q.sts_input = 8'h00;
    nxt_q.sts_input[ssc_pkg::POS_MOUSE] = events_in.mouse_event;
    nxt_q.sts_input[ssc_pkg::POS_KEYBOARD] = events_in.keyboard_event;
    nxt_q.sts_input[ssc_pkg::POS_INFRARED] = ir_next[ssc_pkg::POS_INFRARED];
    nxt_q.sts_input[ssc_pkg::POS_AUX] = aux_next[ssc_pkg::POS_AUX];
    // Pin latches, reserved bit masked
    nxt_q.sts_pins_lo = w1c(q_ff.sts_pins_lo, pins_lo_s,
      (wr_acc && idx == ssc_pkg::IDX_STS_PINS_LO) ? wd : 8'h00)
      & ssc_pkg::MASK_STS_PINS_LO;
    nxt_q.sts_pins_hi = w1c(q_ff.sts_pins_hi, pins_hi_s,
      (wr_acc && idx == ssc_pkg::IDX_STS_PINS_HI) ? wd : 8'h00)
      & ssc_pkg::MASK_STS_PINS_HI;
    // Enable and control writes
    if (wr_acc && idx == ssc_pkg::IDX_EN_PERIPH)
    begin
      nxt_q.en_periph = wd & ssc_pkg::MASK_EN_PERIPH;
    end
    if (wr_acc && idx == ssc_pkg::IDX_EN_INPUT)
    begin
      nxt_q.en_input = wd & ssc_pkg::MASK_EN_INPUT;
    end
    if (wr_acc && idx == ssc_pkg::IDX_CTRL)
    begin
      nxt_q.ctrl = wd & ssc_pkg::MASK_CTRL;
    end
    // Group SMI from enabled status; routes lag it by one cycle
    nxt_q.group_smi = |(q_ff.sts_periph & q_ff.en_periph) |
      |(q_ff.sts_input & q_ff.en_input & ssc_pkg::MASK_STS_INPUT);
    nxt_q.smi_pin_oe = q_ff.en_input[ssc_pkg::POS_PIN_ROUTE];
    nxt_q.smi_pin_n = !(q_ff.group_smi && q_ff.en_input[ssc_pkg::POS_PIN_ROUTE]);
    nxt_q.smi_serial = q_ff.group_smi && q_ff.en_input[ssc_pkg::POS_SERIAL_ROUTE];
    nxt_q.smi_pme = q_ff.group_smi && q_ff.en_input[ssc_pkg::POS_PME_ROUTE];
  end

  ////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      q_ff.sts_periph <= ssc_pkg::RST_STS_PERIPH;
      q_ff.sts_input <= ssc_pkg::RST_ZERO8;
      q_ff.sts_pins_lo <= ssc_pkg::RST_ZERO8;
      q_ff.sts_pins_hi <= ssc_pkg::RST_ZERO8;
      q_ff.en_periph <= ssc_pkg::RST_ZERO8;
      q_ff.en_input <= ssc_pkg::RST_ZERO8;
      q_ff.ctrl <= ssc_pkg::RST_ZERO8;
      q_ff.ir_prev <= 1'b0;
      q_ff.waitrequest <= 1'b1;
      q_ff.readdata <= ssc_pkg::RST_RDATA;
      q_ff.group_smi <= 1'b0;
      q_ff.smi_pin_n <= 1'b1;
      q_ff.smi_pin_oe <= 1'b0;
      q_ff.smi_serial <= 1'b0;
      q_ff.smi_pme <= 1'b0;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  // Outputs straight from the state register
  assign avs_readdata_out = q_ff.readdata;
  assign avs_waitrequest_out = q_ff.waitrequest;
  assign smi_output_pin_n_out = q_ff.smi_pin_n;
  assign smi_output_pin_oe_out = q_ff.smi_pin_oe;
  assign smi_serial_request_out = q_ff.smi_serial;
  assign smi_pme_request_out = q_ff.smi_pme;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Sources gathered into plain signals so that $past sees a signal
  logic [3:0] chk_periph_src;
  logic [1:0] chk_input_src;
  logic chk_group_src;
  assign chk_periph_src = {events_in.midi_port_event, events_in.floppy_event,
                           events_in.first_serial_event, events_in.second_serial_event};
  assign chk_input_src = {events_in.keyboard_event, events_in.mouse_event};
  assign chk_group_src = |(q_ff.sts_periph & q_ff.en_periph) |
                         |(q_ff.sts_input & q_ff.en_input & ssc_pkg::MASK_STS_INPUT);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_input_read_accept;
    rd_acc && idx == ssc_pkg::IDX_STS_INPUT && q_ff.readdata[2];
  endsequence

  sequence s_aux_clear_write;
    wr_acc && idx == ssc_pkg::IDX_STS_INPUT && wd[4];
  endsequence

  AST_PARALLEL_ON_RESET: assert property (
    any_reset_s |=> q_ff.sts_periph[1])
    else $error("parallel status not forced high by reset");

  AST_PARALLEL_IDLE: assert property (
    !q_ff.ctrl[0] |=> q_ff.sts_periph[1])
    else $error("parallel status low while port inactive");

  AST_PARALLEL_TRACK: assert property (
    q_ff.ctrl[0] && !any_reset_s |=> q_ff.sts_periph[1] == $past(ack_s))
    else $error("parallel status not tracking acknowledge");

  AST_PERIPH_MIRROR: assert property (
    1'b1 |=> q_ff.sts_periph[5:2] == $past(chk_periph_src))
    else $error("peripheral status not mirroring sources");

  AST_INPUT_MIRROR: assert property (
    1'b1 |=> q_ff.sts_input[1:0] == $past(chk_input_src))
    else $error("mouse or keyboard status not mirroring");

  AST_RESERVED_ZERO: assert property (
    q_ff.sts_periph[7:6] == 2'b00 && !q_ff.sts_periph[0] &&
    q_ff.sts_input[7:5] == 3'b000 && !q_ff.sts_input[3] && !q_ff.sts_pins_lo[3])
    else $error("reserved status bit set");

  AST_IR_EDGE_SETS: assert property (
    ir_edge |=> q_ff.sts_input[2])
    else $error("infrared edge lost");

  AST_IR_READ_CLEARS: assert property (
    s_input_read_accept and !ir_edge |=> !q_ff.sts_input[2])
    else $error("infrared bit survived read");

  AST_AUX_W1C: assert property (
    s_aux_clear_write and !events_in.aux_line_event |=> !q_ff.sts_input[4])
    else $error("aux status not cleared by write one");

  AST_AUX_HOLDS: assert property (
    events_in.aux_line_event |=> q_ff.sts_input[4])
    else $error("aux status low while event held");

  AST_PIN_LATCH: assert property (
    q_ff.sts_pins_hi[0] && !(wr_acc && idx == ssc_pkg::IDX_STS_PINS_HI && wd[0])
    |=> q_ff.sts_pins_hi[0])
    else $error("pin status dropped without write one");

  AST_GROUP_OR: assert property (
    1'b1 |=> q_ff.group_smi == $past(chk_group_src))
    else $error("group SMI not OR of enabled status");

  AST_PIN_ROUTE: assert property (
    q_ff.group_smi && q_ff.en_input[7] |=> !smi_output_pin_n_out ##0
      smi_output_pin_oe_out)
    else $error("SMI pin not driven");

  AST_SERIAL_ROUTE: assert property (
    !q_ff.en_input[6] |=> !smi_serial_request_out)
    else $error("serial SMI without route enable");

  AST_BUS_ANSWER: assert property (
    (avs_req_in.read || avs_req_in.write) |-> ##[0:1] !avs_waitrequest_out)
    else $error("bus request not answered");

endmodule

// ### logic/ssc_pkg.sv
/*
  Shared constants and types for the SMI status collector: register
  indices, field positions, reset values and the bundles that carry the
  event inputs, the bus request and the collector's state.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package ssc_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_STS_PERIPH = 6'h10;
  localparam logic [5:0] IDX_STS_INPUT = 6'h11;
  localparam logic [5:0] IDX_STS_PINS_LO = 6'h12;
  localparam logic [5:0] IDX_STS_PINS_HI = 6'h13;
  localparam logic [5:0] IDX_EN_PERIPH = 6'h16;
  localparam logic [5:0] IDX_EN_INPUT = 6'h17;
  localparam logic [5:0] IDX_CTRL = 6'h18;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0] RST_STS_PERIPH = 8'h02;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int POS_PARALLEL = 1;
  localparam int POS_SERIAL2 = 2;
  localparam int POS_SERIAL1 = 3;
  localparam int POS_FLOPPY = 4;
  localparam int POS_MIDI = 5;
  localparam int POS_MOUSE = 0;
  localparam int POS_KEYBOARD = 1;
  localparam int POS_INFRARED = 2;
  localparam int POS_AUX = 4;
  localparam int POS_PME_ROUTE = 5;
  localparam int POS_SERIAL_ROUTE = 6;
  localparam int POS_PIN_ROUTE = 7;
  localparam int POS_PORT_ACTIVE = 0;
  localparam int POS_IR_SELECT = 1;

  // Writable / defined bit masks, everything else reads zero
  localparam logic [7:0] MASK_STS_PERIPH = 8'h3E;
  localparam logic [7:0] MASK_STS_INPUT = 8'h17;
  localparam logic [7:0] MASK_STS_PINS_LO = 8'hF7;
  localparam logic [7:0] MASK_STS_PINS_HI = 8'hFF;
  localparam logic [7:0] MASK_EN_PERIPH = 8'h3E;
  localparam logic [7:0] MASK_EN_INPUT = 8'hF7;
  localparam logic [7:0] MASK_CTRL = 8'h03;

  // Width of the pin bundle passed through the synchroniser
  localparam int SYNC_W = 22;

  ////////////////////////////////////////////////////////////////////////
  // Peripheral events from logic on the same clock, active high levels
  typedef struct packed {
    logic second_serial_event;
    logic first_serial_event;
    logic floppy_event;
    logic midi_port_event;
    logic mouse_event;
    logic keyboard_event;
    logic aux_line_event;
  } ssc_events_t;

  // Avalon-MM request from the master
  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } ssc_avs_req_t;

  // Complete state of the collector
  typedef struct packed {
    logic [7:0] sts_periph;
    logic [7:0] sts_input;
    logic [7:0] sts_pins_lo;
    logic [7:0] sts_pins_hi;
    logic [7:0] en_periph;
    logic [7:0] en_input;
    logic [7:0] ctrl;
    logic ir_prev;
    logic waitrequest;
    logic [31:0] readdata;
    logic group_smi;
    logic smi_pin_n;
    logic smi_pin_oe;
    logic smi_serial;
    logic smi_pme;
  } ssc_state_t;

endpackage

// ### logic/ssc_sync2.sv
/*
  Two flip-flop synchroniser for a bundle of asynchronous levels.
  Assumes each bit is an independent level; no bundle coherence.
*/
`timescale 1ns/1ps

module ssc_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in, // System clock
  input wire logic reset_n_in, // Async reset, active low
  input wire logic [WIDTH-1:0] async_in, // Levels from outside the domain
  output logic [WIDTH-1:0] sync_out // Synchronised levels
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  ////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule

// ### verif/ssc_chipset_model.sv
/*
  Chipset side of the group SMI: resolves the shared SMI pin with its
  pull-up and reports whether an SMI arrives by pin or serial stream.
  Assumes the collector is the only driver of the pin.
*/
`timescale 1ns/1ps

module ssc_chipset_model (
  input wire logic pin_n_in, // Driven pin value, active low
  input wire logic pin_oe_in, // Pin output enable
  input wire logic serial_in, // Group SMI on the serial stream
  output logic pin_level_out, // Resolved wire level
  output logic smi_seen_out // SMI seen on either route
);
  // Pull-up holds the wire high whenever nobody drives it
  assign pin_level_out = pin_oe_in ? pin_n_in : 1'b1;
  // Either route counts as a request toward the chipset
  assign smi_seen_out = !pin_level_out || serial_in;
endmodule

// ### verif/ssc_collector_tb_top.sv
/*
  Self-checking bench for the SMI status collector, one task a scenario.
  Assumes the Avalon-MM slave answers every request with waitrequest low.
*/
`timescale 1ns/1ps

module ssc_collector_tb_top;
`define chk(a, e) \
  begin \
    cmp_count++; \
    if ((a) !== (e)) \
      $display("unexpected at %0t: got %h expected %h", $time, a, e); \
    if ((a) !== (e)) \
      err_total++; \
  end

  logic clk_in, reset_n_in, main_rst, hard_rst, soft_rst, ack, ir_a, ir_b;
  logic wreq, pin_n, pin_oe, serial, pme, pin_level, smi_seen;
  logic [7:0] pins_lo, pins_hi;
  logic [31:0] rdata;
  ssc_pkg::ssc_events_t ev;
  ssc_pkg::ssc_avs_req_t req;
  int err_total, cmp_count;

  ssc_collector ssc_collector_i (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .main_power_reset_in(main_rst), .hard_reset_in(hard_rst), .soft_reset_in(soft_rst),
    .events_in(ev), .printer_acknowledge_in(ack), .infrared_receive_a_in(ir_a),
    .infrared_receive_b_in(ir_b), .io_pins_low_in(pins_lo), .io_pins_high_in(pins_hi),
    .avs_req_in(req), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .smi_output_pin_n_out(pin_n), .smi_output_pin_oe_out(pin_oe),
    .smi_serial_request_out(serial), .smi_pme_request_out(pme));
  ssc_chipset_model ssc_chipset_model_i (.pin_n_in(pin_n), .pin_oe_in(pin_oe),
    .serial_in(serial), .pin_level_out(pin_level), .smi_seen_out(smi_seen));

  ////////////////////////////////////////////////////////////////////////
  // One bus cycle; the request holds until a rising edge samples
  // waitrequest low, read data is taken at that edge, then released
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    @(posedge clk_in);
    req.read <= !wr;
    req.write <= wr;
    req.address <= {idx, 2'h0};
    req.writedata <= 32'(d);
    req.byteenable <= 4'h1;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (wreq !== 1'b0)
      err_total++;
    q = rdata[7:0];
    req.read <= 1'b0;
    req.write <= 1'b0;
  endtask

  task automatic wrd(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    `chk(q, e)
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rdc(ssc_pkg::IDX_STS_PERIPH, 8'h02);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h00);
    rdc(ssc_pkg::IDX_STS_PINS_LO, 8'h00);
    rdc(ssc_pkg::IDX_STS_PINS_HI, 8'h00);
    rdc(6'h3F, 8'h00);
    `chk({pin_oe, pin_n, serial, pme}, 4'h4)
  endtask

  // Mirror bits follow their sources and shrug off writes of all ones
  task automatic t_periph();
    for (int k = 0; k < 4; k++)
    begin
      ev <= ssc_pkg::ssc_events_t'(7'h40 >> k);
      tick(2);
      rdc(ssc_pkg::IDX_STS_PERIPH, 8'h02 | (8'h04 << k));
      wrd(ssc_pkg::IDX_STS_PERIPH, 8'hFF);
      rdc(ssc_pkg::IDX_STS_PERIPH, 8'h02 | (8'h04 << k));
      ev <= '0;
      tick(2);
      rdc(ssc_pkg::IDX_STS_PERIPH, 8'h02);
    end
    ack <= 1'b0;
    tick(5);
    rdc(ssc_pkg::IDX_STS_PERIPH, 8'h02);
    wrd(ssc_pkg::IDX_CTRL, 8'h01);
    tick(2);
    rdc(ssc_pkg::IDX_STS_PERIPH, 8'h00);
    ack <= 1'b1;
    tick(5);
    rdc(ssc_pkg::IDX_STS_PERIPH, 8'h02);
  endtask

  task automatic t_input();
    for (int k = 0; k < 2; k++)
    begin
      ev <= ssc_pkg::ssc_events_t'(7'h04 >> k);
      tick(2);
      rdc(ssc_pkg::IDX_STS_INPUT, 8'h01 << k);
      wrd(ssc_pkg::IDX_STS_INPUT, 8'h03);
      rdc(ssc_pkg::IDX_STS_INPUT, 8'h01 << k);
      ev <= '0;
      tick(2);
      rdc(ssc_pkg::IDX_STS_INPUT, 8'h00);
    end
  endtask

  // Both receive inputs are level before the select flips, so no edge
  task automatic t_infrared();
    ir_a <= 1'b1;
    tick(5);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h04);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h00);
    ir_b <= 1'b1;
    tick(5);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h00);
    wrd(ssc_pkg::IDX_CTRL, 8'h03);
    tick(5);
    ir_b <= 1'b0;
    tick(5);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h04);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h00);
  endtask

  task automatic t_aux();
    ev <= ssc_pkg::ssc_events_t'(7'h01);
    tick(2);
    wrd(ssc_pkg::IDX_STS_INPUT, 8'h10);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h10);
    ev <= '0;
    tick(2);
    wrd(ssc_pkg::IDX_STS_INPUT, 8'h00);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h10);
    wrd(ssc_pkg::IDX_STS_INPUT, 8'h10);
    rdc(ssc_pkg::IDX_STS_INPUT, 8'h00);
  endtask

  // One short pin pulse per bit; the latch must outlive the pulse
  task automatic t_pins();
    logic [5:0] idx;
    logic [7:0] e;
    for (int r = 0; r < 2; r++)
      for (int i = 0; i < 8; i++)
      begin
        idx = r ? ssc_pkg::IDX_STS_PINS_HI : ssc_pkg::IDX_STS_PINS_LO;
        e = (r ? 8'hFF : 8'hF7) & (8'h01 << i);
        if (r)
          pins_hi <= 8'h01 << i;
        else
          pins_lo <= 8'h01 << i;
        tick(4);
        pins_hi <= 8'h00;
        pins_lo <= 8'h00;
        tick(5);
        rdc(idx, e);
        wrd(idx, 8'h00);
        rdc(idx, e);
        wrd(idx, 8'hFF);
        rdc(idx, 8'h00);
      end
  endtask

  task automatic t_route();
    wrd(ssc_pkg::IDX_EN_INPUT, 8'hE0);
    ev <= ssc_pkg::ssc_events_t'(7'h10);
    tick(4);
    `chk({pin_oe, pin_n, serial, pme}, 4'hC)
    wrd(ssc_pkg::IDX_EN_PERIPH, 8'h10);
    tick(3);
    `chk({pin_oe, pin_n, serial, pme}, 4'hB)
    `chk(smi_seen, 1'b1)
    wrd(ssc_pkg::IDX_EN_INPUT, 8'h80);
    tick(3);
    `chk({pin_oe, pin_n, serial, pme}, 4'h8)
    wrd(ssc_pkg::IDX_EN_INPUT, 8'h40);
    tick(3);
    `chk({pin_oe, serial, pin_level}, 3'h3)
    wrd(ssc_pkg::IDX_EN_INPUT, 8'hE0);
    ev <= '0;
    tick(4);
    `chk({pin_oe, pin_n, serial, pme}, 4'hC)
    wrd(ssc_pkg::IDX_EN_PERIPH, 8'h00);
  endtask

  // Port stays active with acknowledge low, so only the force sets bit 1
  task automatic t_resets();
    ack <= 1'b0;
    for (int j = 0; j < 3; j++)
    begin
      {main_rst, hard_rst, soft_rst} <= 3'h4 >> j;
      tick(5);
      rdc(ssc_pkg::IDX_STS_PERIPH, 8'h02);
      {main_rst, hard_rst, soft_rst} <= 3'h0;
      tick(5);
      rdc(ssc_pkg::IDX_STS_PERIPH, 8'h00);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Free-running 125 MHz clock
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Hang guard, far beyond the several hundred cycles the run needs
  initial
  begin
    #400000;
    err_total++;
    results();
  end

  // Main sequence
  initial
  begin
    {reset_n_in, main_rst, hard_rst, soft_rst} = 4'h0;
    {ack, ir_a, ir_b} = 3'h4;
    {pins_lo, pins_hi} = 16'h0000;
    ev = '0;
    req = '0;
    err_total = 0;
    cmp_count = 0;
    tick(5);
    reset_n_in <= 1'b1;
    t_reset();
    t_periph();
    t_input();
    t_infrared();
    t_aux();
    t_pins();
    t_route();
    t_resets();
    results();
  end
endmodule
